// file: common/pmsr_defs.svh
// offsets, field positions, reset values and timing counts of the system registers
`ifndef PMSR_DEFS_SVH
`define PMSR_DEFS_SVH

// ****************************************
// register locations selected by the pointer
// ****************************************
`define PMSR_OFS_POINTER 16'h0000
`define PMSR_OFS_DATECODE 16'h0002
`define PMSR_OFS_PINSTATE 16'h001E
`define PMSR_OFS_CONFIG 16'h0042
`define PMSR_OFS_SHIFTS 16'h0048

// ****************************************
// field positions
// ****************************************
`define PMSR_GAIN1_LSB 27
`define PMSR_GAIN0_LSB 24
`define PMSR_TRIM_LSB 16
`define PMSR_SWIRE_BIT 8
`define PMSR_SRST_LSB 6
`define PMSR_SHDN_LSB 4
`define PMSR_REFDIS_BIT 2
`define PMSR_CONV_VOLT 1
`define PMSR_CONV_CURR 0
`define PMSR_PIN_LSB 3
`define PMSR_ADDR_LSB 1
`define PMSR_MULTI_BIT 0
`define PMSR_PWR_LSB 16
`define PMSR_CUR_LSB 8
`define PMSR_VOLT_LSB 0

// ****************************************
// reset values, writable masks, timing
// ****************************************
`define PMSR_CONFIG_RESET 32'h0042_0000
`define PMSR_CONFIG_WMASK 32'h3FFF_01F4
`define PMSR_SHIFTS_RESET 32'h0000_0000
`define PMSR_SHIFTS_WMASK 32'h00FF_FFFF
`define PMSR_GAIN_MAX_CODE 3'h5
`define PMSR_STRAP_SETTLE 4'h4
`define PMSR_SAMPLE_W 24

`endif

// file: common/pmsr_pkg.sv
// types shared by the system register bank
`include "pmsr_defs.svh"
package pmsr_pkg;
  // gain as a power of two exponent, gain = 2**value
  typedef logic [2:0] pmsr_gain_t;

  // whole state of the register bank
  typedef struct packed {
    logic [15:0] ptr;
    logic [31:0] cfg;
    logic [31:0] shifts;
    logic [6:0] pinSync0;
    logic [6:0] pinSync1;
    logic [6:0] pinSync2;
    logic [6:0] pinStable;
    logic [3:0] settleCnt;
    logic strapDone;
    logic [2:0] strap;
    logic [31:0] rdData;
    logic rdValid;
    logic cmdErr;
    logic [`PMSR_SAMPLE_W-1:0] voltSample;
    logic [`PMSR_SAMPLE_W-1:0] currSample;
  } pmsr_state_t;
endpackage

// file: verilog/pmsr_system_regs.sv
// system register bank of the power monitor: pointer, date code, pin state, config, shifts
//
// Function
// - pointer selects target of every access
// - only set-pointer command changes the pointer
// - date code register fixed and read-only
// - status bits 6:3 show input pin levels
// - status bits 2:1 hold address straps
// - status bit 0 one when mode low
// - channel 1 gain codes, reserved means one
// - channel 0 gain uses same encoding
// - soft-reset field selects converters held
// - held converter runs, samples forced zero
// - shutdown field powers converters down independently
// - clearing shutdown re-enables that converter
// - reference trim field, reset value 0x42
// - single-wire auto transmit enable, default off
// - reference disable bit, default enabled
// - range word holds three shift bytes
// - power shift scales active and reactive
// - range byte layout, top byte zero
`timescale 1ns/1ps
`include "pmsr_defs.svh"
module pmsr_system_regs #(
  parameter logic [15:0] DATE_CODE = 16'hA115, // arbitrary value
  parameter int SAMPLE_W = 24
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic setPtrStb,
  input wire logic [15:0] setPtrData,
  input wire logic wrStb,
  input wire logic [31:0] wrData,
  input wire logic rdStb,
  output logic [31:0] rdData,
  output logic rdValid,
  output logic cmdErr,
  input wire logic [3:0] gpPin,
  input wire logic [3:0] gpPinIsInput,
  input wire logic [1:0] addrStrapPins,
  input wire logic modeStrapPin,
  input wire logic [SAMPLE_W-1:0] voltSampleIn,
  input wire logic [SAMPLE_W-1:0] currSampleIn,
  output logic [SAMPLE_W-1:0] voltSampleOut,
  output logic [SAMPLE_W-1:0] currSampleOut,
  output pmsr_pkg::pmsr_gain_t gainSelCh1,
  output pmsr_pkg::pmsr_gain_t gainSelCh0,
  output logic voltConvSoftReset,
  output logic currConvSoftReset,
  output logic voltConvEnable,
  output logic currConvEnable,
  output logic [7:0] refTempcoTrim,
  output logic refDisable,
  output logic singleWireEn,
  output logic [15:0] targetPointer,
  output logic [7:0] activePowerShift,
  output logic [7:0] reactivePowerShift,
  output logic [7:0] currentRmsShift,
  output logic [7:0] voltageRmsShift
);
  import pmsr_pkg::*;

  // ****************************************
  // elaboration checks
  // ****************************************
  // the state struct carries samples at a fixed width
  if (SAMPLE_W != `PMSR_SAMPLE_W) begin : g_badWidth
    $error("SAMPLE_W must match the state struct sample width");
  end

  // ****************************************
  // helpers
  // ****************************************
  // reserved gain codes fall back to unity gain
  function automatic pmsr_gain_t gainExp(input logic [2:0] code);
    if (code > `PMSR_GAIN_MAX_CODE) begin
      gainExp = 3'h0;
    end else begin
      gainExp = code;
    end
  endfunction

  // masked update, unimplemented bits stay zero
  function automatic logic [31:0] maskedWrite(input logic [31:0] data, input logic [31:0] mask);
    maskedWrite = data & mask;
  endfunction

  pmsr_state_t st;
  pmsr_state_t next_st;
  logic [15:0] statusWord;
  logic [32:0] readHit;
  logic cmdSetPtr;
  logic cmdWrite;
  logic cmdRead;

  // ****************************************
  // command decode
  // ****************************************
  // one command per cycle; set-pointer wins, then write, then read
  assign cmdSetPtr = setPtrStb;
  assign cmdWrite = wrStb && !setPtrStb;
  assign cmdRead = rdStb && !setPtrStb && !wrStb;

  // status word: live input pins plus straps caught after reset
  always_comb begin
    statusWord = 16'h0000;
    statusWord[`PMSR_PIN_LSB +: 4] = st.pinStable[3:0] & gpPinIsInput;
    statusWord[`PMSR_ADDR_LSB +: 2] = st.strap[2:1];
    statusWord[`PMSR_MULTI_BIT] = st.strap[0];
  end

  // read mux addressed by the pointer; top bit flags a mapped location
  always_comb begin
    case (st.ptr)
      `PMSR_OFS_POINTER: begin
        readHit = {1'b1, 16'h0000, st.ptr};
      end
      `PMSR_OFS_DATECODE: begin
        readHit = {1'b1, 16'h0000, DATE_CODE};
      end
      `PMSR_OFS_PINSTATE: begin
        readHit = {1'b1, 16'h0000, statusWord};
      end
      `PMSR_OFS_CONFIG: begin
        readHit = {1'b1, st.cfg};
      end
      `PMSR_OFS_SHIFTS: begin
        readHit = {1'b1, st.shifts};
      end
      default: begin
        readHit = 33'h0_0000_0000;
      end
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.rdValid = 1'b0;
    next_st.cmdErr = 1'b0;
    // pin synchroniser: three flops, a change counts when stages two and three agree
    next_st.pinSync0 = {modeStrapPin, addrStrapPins, gpPin};
    next_st.pinSync1 = st.pinSync0;
    next_st.pinSync2 = st.pinSync1;
    for (int i = 0; i < 7; i++) begin
      if (st.pinSync1[i] == st.pinSync2[i]) begin
        next_st.pinStable[i] = st.pinSync2[i];
      end
    end
    // straps are caught once after release and then frozen
    if (!st.strapDone) begin
      if (st.settleCnt == `PMSR_STRAP_SETTLE) begin
        next_st.strapDone = 1'b1;
        next_st.strap = {st.pinStable[5:4], !st.pinStable[6]};
      end else begin
        next_st.settleCnt = st.settleCnt + 4'h1;
      end
    end
    // pointer moves only on its own command; writes never reach it
    if (cmdSetPtr) begin
      next_st.ptr = setPtrData;
    end
    // register writes land at the pointer; read-only locations refuse
    if (cmdWrite) begin
      case (st.ptr)
        `PMSR_OFS_CONFIG: begin
          next_st.cfg = maskedWrite(wrData, `PMSR_CONFIG_WMASK);
        end
        `PMSR_OFS_SHIFTS: begin
          next_st.shifts = maskedWrite(wrData, `PMSR_SHIFTS_WMASK);
        end
        default: begin
          next_st.cmdErr = 1'b1;
        end
      endcase
    end
    // reads answer one cycle later from a flop
    if (cmdRead) begin
      next_st.rdValid = 1'b1;
      next_st.rdData = readHit[31:0];
      next_st.cmdErr = !readHit[32];
    end
    // a held converter keeps running but its samples read as zero
    if (st.cfg[`PMSR_SRST_LSB + `PMSR_CONV_VOLT]) begin
      next_st.voltSample = '0;
    end else begin
      next_st.voltSample = voltSampleIn;
    end
    if (st.cfg[`PMSR_SRST_LSB + `PMSR_CONV_CURR]) begin
      next_st.currSample = '0;
    end else begin
      next_st.currSample = currSampleIn;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
      st.cfg <= `PMSR_CONFIG_RESET;
      st.shifts <= `PMSR_SHIFTS_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // every control output but targetPointer comes from the config or range flops, the gains through the reserved-code fallback
  assign rdData = st.rdData;
  assign rdValid = st.rdValid;
  assign cmdErr = st.cmdErr;
  assign targetPointer = st.ptr;
  assign voltSampleOut = st.voltSample;
  assign currSampleOut = st.currSample;
  assign gainSelCh1 = gainExp(st.cfg[`PMSR_GAIN1_LSB +: 3]);
  assign gainSelCh0 = gainExp(st.cfg[`PMSR_GAIN0_LSB +: 3]);
  assign voltConvSoftReset = st.cfg[`PMSR_SRST_LSB + `PMSR_CONV_VOLT];
  assign currConvSoftReset = st.cfg[`PMSR_SRST_LSB + `PMSR_CONV_CURR];
  // enable is the inverse of the shutdown bit; clearing the bit raises enable again
  assign voltConvEnable = !st.cfg[`PMSR_SHDN_LSB + `PMSR_CONV_VOLT];
  assign currConvEnable = !st.cfg[`PMSR_SHDN_LSB + `PMSR_CONV_CURR];
  assign refTempcoTrim = st.cfg[`PMSR_TRIM_LSB +: 8];
  assign refDisable = st.cfg[`PMSR_REFDIS_BIT];
  assign singleWireEn = st.cfg[`PMSR_SWIRE_BIT];
  // one power byte feeds both power paths so their scales cannot drift apart
  assign activePowerShift = st.shifts[`PMSR_PWR_LSB +: 8];
  assign reactivePowerShift = st.shifts[`PMSR_PWR_LSB +: 8];
  assign currentRmsShift = st.shifts[`PMSR_CUR_LSB +: 8];
  assign voltageRmsShift = st.shifts[`PMSR_VOLT_LSB +: 8];
  // shift size against overflow is the host's choice, not checked here

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // steps of config and range writes and of config, date code and status reads
  sequence seqCfgWrite;
    wrStb && !setPtrStb && (st.ptr == `PMSR_OFS_CONFIG);
  endsequence

  sequence seqCfgRead;
    rdStb && !setPtrStb && !wrStb && (st.ptr == `PMSR_OFS_CONFIG);
  endsequence

  sequence seqDateRead;
    rdStb && !setPtrStb && !wrStb && (st.ptr == `PMSR_OFS_DATECODE);
  endsequence

  sequence seqShiftWrite;
    wrStb && !setPtrStb && (st.ptr == `PMSR_OFS_SHIFTS);
  endsequence

  sequence seqStatusRead;
    rdStb && !setPtrStb && !wrStb && (st.ptr == `PMSR_OFS_PINSTATE);
  endsequence

  AST_PTR_ONLY_BY_SET: assert property ((targetPointer != $past(targetPointer)) |-> $past(setPtrStb))
    else $error("pointer changed without set-pointer command");

  AST_PTR_LOADS: assert property (setPtrStb |=> targetPointer == $past(setPtrData))
    else $error("pointer did not load set-pointer data");

  AST_DATE_READ: assert property (seqDateRead |=> rdValid && rdData == {16'h0000, DATE_CODE} && !cmdErr)
    else $error("date code read returned wrong value");

  AST_DATE_NO_WRITE: assert property (wrStb && !setPtrStb && st.ptr == `PMSR_OFS_DATECODE |=> cmdErr)
    else $error("write to date code not refused");

  AST_CFG_READBACK: assert property (seqCfgWrite ##1 seqCfgRead |=>
    rdValid && rdData == ($past(wrData, 2) & `PMSR_CONFIG_WMASK))
    else $error("config readback differs from masked write");

  AST_CFG_RESERVED_ZERO: assert property ((st.cfg & ~`PMSR_CONFIG_WMASK) == 32'h0000_0000)
    else $error("unimplemented config bit is set");

  AST_RANGE_TOP_ZERO: assert property (st.shifts[31:24] == 8'h00)
    else $error("range top byte not zero");

  AST_GAIN1_RESERVED: assert property (st.cfg[`PMSR_GAIN1_LSB +: 3] > 3'h5 |-> gainSelCh1 == 3'h0)
    else $error("reserved channel 1 gain not unity");

  AST_GAIN0_RESERVED: assert property (st.cfg[`PMSR_GAIN0_LSB +: 3] > 3'h5 |-> gainSelCh0 == 3'h0)
    else $error("reserved channel 0 gain not unity");

  AST_VOLT_HELD_ZERO: assert property (voltConvSoftReset [*2] |-> voltSampleOut == '0)
    else $error("held voltage converter sample not zero");

  AST_CURR_PASS: assert property (!currConvSoftReset |=> currSampleOut == $past(currSampleIn))
    else $error("current sample not passed through");

  AST_SHDN_RELEASE: assert property ($fell(st.cfg[`PMSR_SHDN_LSB + `PMSR_CONV_CURR]) |-> currConvEnable)
    else $error("current converter not re-enabled");

  AST_STRAP_FROZEN: assert property (st.strapDone && $past(st.strapDone) |-> $stable(st.strap))
    else $error("strap bits changed after capture");

  AST_MODE_INVERT: assert property ($rose(st.strapDone) |-> st.strap[0] == !$past(st.pinStable[6]))
    else $error("multiple-device bit not inverse of mode pin");

  AST_POWER_BOTH: assert property (activePowerShift == reactivePowerShift)
    else $error("power shifts differ");

  // write paths tied to the word on the bus, not to the flops they fill
  AST_CFG_WRITE_LANDS: assert property (seqCfgWrite |=> st.cfg == ($past(wrData) & `PMSR_CONFIG_WMASK))
    else $error("config write did not land masked");

  AST_SHDN_WRITE: assert property (seqCfgWrite |=>
    {voltConvEnable, currConvEnable} == ~$past(wrData[`PMSR_SHDN_LSB +: 2]))
    else $error("converter enables do not follow shutdown field");

  AST_SHIFT_WRITE: assert property (seqShiftWrite |=> st.shifts == ($past(wrData) & `PMSR_SHIFTS_WMASK))
    else $error("range write did not land masked");

  AST_POWER_WRITE: assert property (seqShiftWrite |=>
    activePowerShift == $past(wrData[`PMSR_PWR_LSB +: 8]) &&
    reactivePowerShift == $past(wrData[`PMSR_PWR_LSB +: 8]))
    else $error("power shifts do not follow written byte");

  AST_PTR_WRITE_REFUSED: assert property (wrStb && !setPtrStb && st.ptr == `PMSR_OFS_POINTER |=>
    $stable(targetPointer) && cmdErr)
    else $error("write at pointer location not refused");

  AST_UNMAPPED_READ: assert property (cmdRead && !readHit[32] |=>
    rdValid && cmdErr && rdData == 32'h0000_0000)
    else $error("unmapped read not answered with zero and error");

  AST_STATUS_READ: assert property (seqStatusRead |=> rdValid && rdData[31:7] == 25'h000_0000 &&
    rdData[6:3] == ($past(st.pinStable[3:0]) & $past(gpPinIsInput)))
    else $error("status read does not show input pin levels");

  AST_VOLT_PASS: assert property (!voltConvSoftReset |=> voltSampleOut == $past(voltSampleIn))
    else $error("voltage sample not passed through");

  AST_CURR_HELD_ZERO: assert property (currConvSoftReset [*2] |-> currSampleOut == '0)
    else $error("held current converter sample not zero");

  AST_READ_NEEDS_CMD: assert property (!cmdRead |=> !rdValid)
    else $error("read answer without a read command");

  AST_STRAP_ADDR: assert property ($rose(st.strapDone) |-> st.strap[2:1] == $past(st.pinStable[5:4]))
    else $error("address strap bits not caught from pins");

endmodule

// file: verif/pmsr_host_model.sv
// host model issuing pointer, write and read commands
`timescale 1ns/1ps
module pmsr_host_model (
  input wire logic core_clk,
  output logic setPtrStb,
  output logic [15:0] setPtrData,
  output logic wrStb,
  output logic [31:0] wrData,
  output logic rdStb
);
  // ****************************************
  // command driver
  // ****************************************
  // idle at time zero, nothing requested
  initial begin
    {setPtrStb, wrStb, rdStb} = 3'b000;
    setPtrData = 16'h0000;
    wrData = 32'h0000_0000;
  end

  // kind 0 sets the pointer, 1 writes, 2 reads; only kind 0 moves it
  task automatic issue(input int kind, input logic [31:0] d);
    @(posedge core_clk);
    setPtrStb <= (kind == 0);
    wrStb <= (kind == 1);
    rdStb <= (kind == 2);
    setPtrData <= d[15:0];
    wrData <= d;
    @(posedge core_clk);
    {setPtrStb, wrStb, rdStb} <= 3'b000;
    // released data scrambled so a late sample cannot pass by luck
    setPtrData <= ~d[15:0];
    wrData <= ~d;
  endtask

  // write then read on the very next edge, the pair a readback needs
  task automatic wrRd(input logic [31:0] d);
    @(posedge core_clk);
    wrStb <= 1'b1;
    wrData <= d;
    @(posedge core_clk);
    wrStb <= 1'b0;
    rdStb <= 1'b1;
    wrData <= ~d;
    @(posedge core_clk);
    rdStb <= 1'b0;
  endtask
endmodule

// file: verif/testbench.sv
// self-checking bench for the system register bank
`timescale 1ns/1ps
`include "pmsr_defs.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module testbench;
  import pmsr_pkg::*;
  localparam logic [15:0] DATE = 16'h5A3C; // arbitrary value
  logic core_clk, reset, setPtrStb, wrStb, rdStb, rdValid, cmdErr, modeStrapPin;
  logic [15:0] setPtrData, targetPointer;
  logic [31:0] wrData, rdData, d, e;
  logic [3:0] gpPin, gpPinIsInput;
  logic [1:0] addrStrapPins;
  logic [23:0] voltSampleIn, currSampleIn, voltSampleOut, currSampleOut;
  pmsr_gain_t gainSelCh1, gainSelCh0;
  logic voltConvSoftReset, currConvSoftReset, voltConvEnable, currConvEnable, refDisable, singleWireEn;
  logic [7:0] refTempcoTrim, activePowerShift, reactivePowerShift, currentRmsShift, voltageRmsShift;
  int n_mismatch, checks, errSeen, errExp, seed;
  logic [31:0] expQ[$];

  // ****************************************
  // instances, clock, helpers
  // ****************************************
  pmsr_system_regs #(.DATE_CODE(DATE), .SAMPLE_W(24)) i_dut (.core_clk, .reset, .setPtrStb, .setPtrData,
    .wrStb, .wrData, .rdStb, .rdData, .rdValid, .cmdErr, .gpPin, .gpPinIsInput, .addrStrapPins,
    .modeStrapPin, .voltSampleIn, .currSampleIn, .voltSampleOut, .currSampleOut, .gainSelCh1,
    .gainSelCh0, .voltConvSoftReset, .currConvSoftReset, .voltConvEnable, .currConvEnable,
    .refTempcoTrim, .refDisable, .singleWireEn, .targetPointer, .activePowerShift,
    .reactivePowerShift, .currentRmsShift, .voltageRmsShift);
  pmsr_host_model i_host (.core_clk, .setPtrStb, .setPtrData, .wrStb, .wrData, .rdStb);

  // 250 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // reserved gain codes fall back to unity
  function automatic pmsr_gain_t gsel(input logic [2:0] c);
    return (c > 3'h5) ? 3'h0 : c;
  endfunction

  // pointer then command; refusal expected when flagged
  task automatic access(input logic [15:0] p, input logic [31:0] v, input int refused);
    i_host.issue(0, {16'h0000, p});
    i_host.issue(1, v);
    errExp += refused;
    #1;
  endtask

  // note the expected word before the read is launched
  task automatic rdChk(input logic [15:0] p, input logic [31:0] x);
    i_host.issue(0, {16'h0000, p});
    expQ.push_back(x);
    i_host.issue(2, 32'h0000_0000);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // read answers against the oldest note; refusals counted
  always @(posedge core_clk) begin
    if (cmdErr === 1'b1) errSeen++;
    if (rdValid === 1'b1) begin
      if (expQ.size() > 0) begin
        e = expQ.pop_front();
        `CHK(rdData, e) // word at the pointer
      end else `CHK(rdValid, 1'b0) // no read pending
    end
  end

  // hang guard
  initial begin
    #80000;
    n_mismatch++;
    conclude();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 35279;
    {n_mismatch, checks, errSeen, errExp} = '0;
    reset = 1'b1;
    {gpPin, gpPinIsInput, voltSampleIn, currSampleIn} = '0;
    addrStrapPins = 2'b10;
    modeStrapPin = 1'b0;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    repeat (8) @(posedge core_clk);
    `CHK(refTempcoTrim, 8'h42) // trim default
    `CHK({gainSelCh1, gainSelCh0}, 6'h00) // unity gains
    `CHK({voltConvSoftReset, currConvSoftReset, voltConvEnable, currConvEnable}, 4'b0011) // idle
    `CHK({refDisable, singleWireEn}, 2'b00) // defaults
    rdChk(`PMSR_OFS_CONFIG, `PMSR_CONFIG_RESET); // config default
    rdChk(`PMSR_OFS_SHIFTS, 32'h0000_0000); // range default
    // refused writes: pointer, date code, unmapped
    access(`PMSR_OFS_POINTER, 32'h0000_1234, 1); // pointer location
    `CHK(targetPointer, 16'h0000) // write cannot move pointer
    rdChk(`PMSR_OFS_POINTER, 32'h0000_0000); // pointer unchanged
    access(`PMSR_OFS_DATECODE, 32'h0000_FFFF, 1); // fixed code
    rdChk(`PMSR_OFS_DATECODE, {16'h0000, DATE}); // date code
    access(16'h0044, 32'hFFFF_FFFF, 1); // unmapped write
    `CHK(targetPointer, 16'h0044) // pointer follows command
    rdChk(16'h0044, 32'h0000_0000); // unmapped read
    errExp++;
    // live pins vs straps frozen since reset
    for (int i = 0; i < 6; i++) begin
      d = $random(seed);
      @(posedge core_clk);
      {modeStrapPin, addrStrapPins, gpPinIsInput, gpPin} <= d[10:0];
      repeat (8) @(posedge core_clk);
      rdChk(`PMSR_OFS_PINSTATE, {25'h0, d[3:0] & d[7:4], 3'b101}); // status
      access(`PMSR_OFS_PINSTATE, 32'hFFFF_FFFF, 1); // read-only status
    end
    // every gain code, reset and shutdown pattern
    for (int c = 0; c < 8; c++) begin
      d = $random(seed);
      d[29:24] = {c[2:0], ~c[2:0]};
      d[7:4] = {c[1:0], c[2:1]};
      access(`PMSR_OFS_CONFIG, d, 0);
      `CHK(gainSelCh1, gsel(c[2:0])) // channel 1 gain
      `CHK(gainSelCh0, gsel(~c[2:0])) // channel 0 gain
      `CHK({voltConvSoftReset, currConvSoftReset}, d[7:6]) // soft reset
      `CHK({voltConvEnable, currConvEnable}, ~d[5:4]) // shutdown
      `CHK({refTempcoTrim, singleWireEn, refDisable}, {d[23:16], d[8], d[2]}) // ref and wire
      @(posedge core_clk);
      voltSampleIn <= d[23:0];
      currSampleIn <= ~d[23:0];
      @(posedge core_clk);
      #1;
      `CHK(voltSampleOut, d[7] ? 24'h00_0000 : d[23:0]) // held at zero
      `CHK(currSampleOut, d[6] ? 24'h00_0000 : ~d[23:0]) // held at zero
      rdChk(`PMSR_OFS_CONFIG, d & `PMSR_CONFIG_WMASK); // unused bits zero
      expQ.push_back(~d & `PMSR_CONFIG_WMASK); // readback note
      i_host.wrRd(~d); // write and read back to back
    end
    // shift counts are the host's own choice
    for (int i = 0; i < 3; i++) begin
      d = $random(seed);
      access(`PMSR_OFS_SHIFTS, d, 0);
      `CHK({activePowerShift, reactivePowerShift}, {2{d[23:16]}}) // shared power shift
      `CHK({currentRmsShift, voltageRmsShift}, d[15:0]) // rms shifts
      rdChk(`PMSR_OFS_SHIFTS, d & `PMSR_SHIFTS_WMASK); // top byte zero
    end
    // second power-up with the straps at their other levels
    @(posedge core_clk);
    {modeStrapPin, addrStrapPins, gpPinIsInput} <= {1'b1, 2'b01, 4'h0};
    reset <= 1'b1;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    repeat (8) @(posedge core_clk);
    rdChk(`PMSR_OFS_PINSTATE, 32'h0000_0002); // straps caught again, single mode
    repeat (4) @(posedge core_clk);
    `CHK(errSeen, errExp) // refusals flagged
    `CHK(expQ.size(), 0) // every read answered
    conclude();
  end
endmodule
